// ### design/ebx_cfg.svh
// Expansion bus master constants: widths, reset values and fixed counts
`ifndef EBX_CFG_SVH
`define EBX_CFG_SVH

`define EBX_ADDR_W 24
`define EBX_DATA_W 16
`define EBX_SHORT_CNT_W 2
`define EBX_LONG_CNT_W 4
// Phase counts hold (cycles - 1); address hold after latch fall is fixed
`define EBX_ALE_HOLD_CNT 4'h0
`define EBX_STROBE_IDLE 1'b1
`define EBX_CS_IDLE 1'b1
`define EBX_WAIT_IDLE 1'b1
`define EBX_ADDR_RST 24'h000000
`define EBX_DATA_RST 16'h0000

`endif

// ### design/ebx_pkg.sv
// Expansion bus master types
`include "ebx_cfg.svh"

package ebx_pkg;

    typedef enum logic [1:0] {
        mode_mux_rw,
        mode_simplex_rw,
        mode_mux_ds,
        mode_simplex_ds
    } ebx_mode_t;

    typedef enum logic [2:0] {
        st_idle,
        st_launch,
        st_addr,
        st_ahold,
        st_setup,
        st_strobe,
        st_hold,
        st_recov
    } ebx_state_t;

    // Each count is cycles - 1
    typedef struct packed {
        logic [`EBX_SHORT_CNT_W-1:0] address_phase_count;
        logic [`EBX_SHORT_CNT_W-1:0] data_setup_phase_count;
        logic [`EBX_LONG_CNT_W-1:0] data_strobe_phase_count;
        logic [`EBX_SHORT_CNT_W-1:0] hold_phase_count;
        logic [`EBX_LONG_CNT_W-1:0] recovery_phase_count;
    } ebx_timing_t;

    typedef struct packed {
        logic write;
        logic [`EBX_ADDR_W-1:0] addr;
        logic [`EBX_DATA_W-1:0] wdata;
    } ebx_req_t;

    typedef struct packed {
        logic ale;
        logic [`EBX_ADDR_W-1:0] addr;
        logic cs_n;
        logic [`EBX_DATA_W-1:0] dout;
        logic doe;
        logic rd_n;
        logic wr_n;
        logic srd_n;
        logic swr_n;
        logic ds_n;
        logic rnw;
    } ebx_pins_t;

endpackage

// ### design/ebx_pin_sync.sv
// Two-flop synchroniser for bus pins and rising-edge tick of the bus clock
`timescale 1ns/1ns
`default_nettype none

module ebx_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Pins
    input wire logic link_clk,
    input wire logic [W-1:0] din,
    // Synchronised
    output logic bus_tick,
    output logic [W-1:0] dout
);

    logic [2:0] clk_ff;
    logic [2:0] nxt_clk;
    logic [W-1:0] d1_ff;
    logic [W-1:0] d2_ff;
    logic [W-1:0] nxt_d1;
    logic [W-1:0] nxt_d2;
    logic tick_ff;
    logic nxt_tick;

    always_comb begin
        nxt_clk = {clk_ff[1:0], link_clk};
        nxt_d1 = din;
        nxt_d2 = d1_ff;
        // Edge taken between second and third stage only
        nxt_tick = clk_ff[1] & ~clk_ff[2];
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            // All ones so a clock already high at release is no edge
            clk_ff <= 3'h7;
            d1_ff <= '0;
            d2_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            clk_ff <= nxt_clk;
            d1_ff <= nxt_d1;
            d2_ff <= nxt_d2;
            tick_ff <= nxt_tick;
        end
    end

    assign bus_tick = tick_ff;
    assign dout = d2_ff;

endmodule

`default_nettype wire

// ### design/ebx_async_master.sv
// Expansion bus master: phased asynchronous accesses in four strobe modes
// Summary of operation
// - Latch strobe high for programmed 1-4 cycles
// - Address held one cycle after latch falls
// - Chip select valid one cycle after latch falls
// - Write data valid setup cycles before strobe
// - Write strobe low for 1-16 cycles
// - Write data held 1-4 cycles after strobe
// - Hold count keeps select, address, data
// - Recovery of 1-16 cycles between accesses
// - Data present throughout the strobe phase
// - Simplex: no latch; select after address phase
// - Simplex write strobe uses same timing
// - Single data strobe uses same timing
// - Read data captured at end of strobe
// - Outputs launched on bus clock rising edge, except write data and direction, set when a request is taken
// - Inputs sampled on bus clock rising edge
`timescale 1ns/1ns
`default_nettype none
`include "ebx_cfg.svh"

module ebx_async_master (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Configuration
    input wire ebx_pkg::ebx_mode_t bus_mode,
    input wire ebx_pkg::ebx_timing_t timing,
    // Request
    input wire logic req_valid,
    input wire ebx_pkg::ebx_req_t req,
    output logic req_ready,
    // Answer
    output logic done,
    output logic [`EBX_DATA_W-1:0] rd_data,
    // Sampled status
    output logic target_selected,
    output logic burst_seen,
    // Bus pins
    input wire logic expansion_bus_clock,
    input wire logic [`EBX_DATA_W-1:0] bus_data_in,
    input wire logic target_select_in_n,
    input wire logic burst_indication,
    output logic address_latch_strobe,
    output logic [`EBX_ADDR_W-1:0] bus_addr,
    output logic chip_select_n,
    output logic [`EBX_DATA_W-1:0] bus_data_out,
    output logic bus_data_oe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic simplex_read_strobe_n,
    output logic simplex_write_strobe_n,
    output logic single_data_strobe_n,
    output logic read_not_write,
    output logic wait_out_n
);

    localparam int SW = `EBX_DATA_W + 2;

    logic bus_tick;
    logic [SW-1:0] sync_q;
    logic [`EBX_DATA_W-1:0] din_s;
    logic tsel_s;
    logic burst_s;

    ebx_pin_sync #(.W(SW)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .link_clk(expansion_bus_clock),
        .din({bus_data_in, target_select_in_n, burst_indication}),
        .bus_tick(bus_tick),
        .dout(sync_q)
    );

    assign din_s = sync_q[SW-1:2];
    assign tsel_s = sync_q[1];
    assign burst_s = sync_q[0];

    ebx_pkg::ebx_state_t st_ff, nxt_st;
    ebx_pkg::ebx_req_t req_ff, nxt_req;
    ebx_pkg::ebx_timing_t tim_ff, nxt_tim;
    ebx_pkg::ebx_mode_t mode_ff, nxt_mode;
    ebx_pkg::ebx_pins_t pins_ff, nxt_pins;
    logic [3:0] cnt_ff, nxt_cnt;
    logic ready_ff, nxt_ready;
    logic done_ff, nxt_done;
    logic [`EBX_DATA_W-1:0] rdata_ff, nxt_rdata;
    logic tsel_ff, nxt_tsel;
    logic burst_ff, nxt_burst;
    logic wait_ff, nxt_wait;
    logic is_mux;
    logic in_cycle;
    logic strobe_on;

    // Length of a phase, as cycles - 1
    function automatic logic [3:0] phase_load(input ebx_pkg::ebx_state_t s,
                                              input ebx_pkg::ebx_timing_t t);
        logic [3:0] v;
        v = 4'h0;
        unique case (s)
            ebx_pkg::st_addr: v = {2'h0, t.address_phase_count};
            ebx_pkg::st_ahold: v = `EBX_ALE_HOLD_CNT;
            ebx_pkg::st_setup: v = {2'h0, t.data_setup_phase_count};
            ebx_pkg::st_strobe: v = t.data_strobe_phase_count;
            ebx_pkg::st_hold: v = {2'h0, t.hold_phase_count};
            ebx_pkg::st_recov: v = t.recovery_phase_count;
            ebx_pkg::st_idle, ebx_pkg::st_launch: v = 4'h0;
        endcase
        return v;
    endfunction

    function automatic ebx_pkg::ebx_state_t next_phase(input ebx_pkg::ebx_state_t s,
                                                        input logic mux);
        ebx_pkg::ebx_state_t n;
        n = s;
        unique case (s)
            ebx_pkg::st_launch: n = ebx_pkg::st_addr;
            ebx_pkg::st_addr: n = mux ? ebx_pkg::st_ahold : ebx_pkg::st_setup;
            ebx_pkg::st_ahold: n = ebx_pkg::st_setup;
            ebx_pkg::st_setup: n = ebx_pkg::st_strobe;
            ebx_pkg::st_strobe: n = ebx_pkg::st_hold;
            ebx_pkg::st_hold: n = ebx_pkg::st_recov;
            ebx_pkg::st_recov: n = ebx_pkg::st_idle;
            ebx_pkg::st_idle: n = ebx_pkg::st_idle;
        endcase
        return n;
    endfunction

    always_comb begin
        nxt_st = st_ff;
        nxt_req = req_ff;
        nxt_tim = tim_ff;
        nxt_mode = mode_ff;
        nxt_cnt = cnt_ff;
        nxt_ready = ready_ff;
        nxt_done = 1'b0;
        nxt_rdata = rdata_ff;
        nxt_tsel = tsel_ff;
        nxt_burst = burst_ff;
        nxt_wait = `EBX_WAIT_IDLE;
        if (bus_tick) begin
            nxt_tsel = ~tsel_s;
            nxt_burst = burst_s;
        end
        is_mux = (mode_ff == ebx_pkg::mode_mux_rw) || (mode_ff == ebx_pkg::mode_mux_ds);
        if (st_ff == ebx_pkg::st_idle) begin
            if (req_valid && ready_ff) begin
                nxt_req = req;
                nxt_tim = timing;
                nxt_mode = bus_mode;
                nxt_ready = 1'b0;
                nxt_st = ebx_pkg::st_launch;
            end
        end else if (bus_tick) begin
            // Phase changes only on a bus clock rising edge
            if (st_ff == ebx_pkg::st_launch || cnt_ff == 4'h0) begin
                nxt_st = next_phase(st_ff, is_mux);
                nxt_cnt = phase_load(nxt_st, tim_ff);
                if (st_ff == ebx_pkg::st_strobe && !req_ff.write) begin
                    nxt_rdata = din_s;
                end
                if (st_ff == ebx_pkg::st_recov) begin
                    nxt_done = 1'b1;
                    nxt_ready = 1'b1;
                end
            end else begin
                nxt_cnt = cnt_ff - 4'h1;
            end
        end
    end

    // Pin levels follow the next phase so they launch with the tick
    always_comb begin
        nxt_pins = pins_ff;
        in_cycle = (nxt_st == ebx_pkg::st_setup) || (nxt_st == ebx_pkg::st_strobe) ||
                   (nxt_st == ebx_pkg::st_hold);
        strobe_on = (nxt_st == ebx_pkg::st_strobe);
        nxt_pins.ale = is_mux && (nxt_st == ebx_pkg::st_addr);
        if (nxt_st == ebx_pkg::st_addr) begin
            nxt_pins.addr = nxt_req.addr;
        end
        nxt_pins.cs_n = ~in_cycle;
        nxt_pins.dout = nxt_req.wdata;
        nxt_pins.doe = in_cycle && nxt_req.write;
        nxt_pins.rd_n = ~(strobe_on && !nxt_req.write && nxt_mode == ebx_pkg::mode_mux_rw);
        nxt_pins.wr_n = ~(strobe_on && nxt_req.write && nxt_mode == ebx_pkg::mode_mux_rw);
        nxt_pins.srd_n = ~(strobe_on && !nxt_req.write &&
                           nxt_mode == ebx_pkg::mode_simplex_rw);
        nxt_pins.swr_n = ~(strobe_on && nxt_req.write &&
                           nxt_mode == ebx_pkg::mode_simplex_rw);
        nxt_pins.ds_n = ~(strobe_on && (nxt_mode == ebx_pkg::mode_mux_ds ||
                                        nxt_mode == ebx_pkg::mode_simplex_ds));
        nxt_pins.rnw = ~(nxt_req.write && (nxt_st != ebx_pkg::st_idle));
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= ebx_pkg::st_idle;
            req_ff <= '0;
            tim_ff <= '0;
            mode_ff <= ebx_pkg::mode_mux_rw;
            cnt_ff <= 4'h0;
            ready_ff <= 1'b1;
            done_ff <= 1'b0;
            rdata_ff <= `EBX_DATA_RST;
            tsel_ff <= 1'b0;
            burst_ff <= 1'b0;
            wait_ff <= `EBX_WAIT_IDLE;
            pins_ff <= '{ale: 1'b0, addr: `EBX_ADDR_RST, cs_n: `EBX_CS_IDLE,
                         dout: `EBX_DATA_RST, doe: 1'b0, rd_n: `EBX_STROBE_IDLE,
                         wr_n: `EBX_STROBE_IDLE, srd_n: `EBX_STROBE_IDLE,
                         swr_n: `EBX_STROBE_IDLE, ds_n: `EBX_STROBE_IDLE, rnw: 1'b1};
        end else begin
            st_ff <= nxt_st;
            req_ff <= nxt_req;
            tim_ff <= nxt_tim;
            mode_ff <= nxt_mode;
            cnt_ff <= nxt_cnt;
            ready_ff <= nxt_ready;
            done_ff <= nxt_done;
            rdata_ff <= nxt_rdata;
            tsel_ff <= nxt_tsel;
            burst_ff <= nxt_burst;
            wait_ff <= nxt_wait;
            pins_ff <= nxt_pins;
        end
    end

    assign req_ready = ready_ff;
    assign done = done_ff;
    assign rd_data = rdata_ff;
    assign target_selected = tsel_ff;
    assign burst_seen = burst_ff;
    assign address_latch_strobe = pins_ff.ale;
    assign bus_addr = pins_ff.addr;
    assign chip_select_n = pins_ff.cs_n;
    assign bus_data_out = pins_ff.dout;
    assign bus_data_oe = pins_ff.doe;
    assign read_strobe_n = pins_ff.rd_n;
    assign write_strobe_n = pins_ff.wr_n;
    assign simplex_read_strobe_n = pins_ff.srd_n;
    assign simplex_write_strobe_n = pins_ff.swr_n;
    assign single_data_strobe_n = pins_ff.ds_n;
    assign read_not_write = pins_ff.rnw;
    assign wait_out_n = wait_ff;

    // Ticks spent in the current phase, for checking
    logic [4:0] ph_ticks;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_ticks <= 5'h00;
        end else if (st_ff != nxt_st) begin
            ph_ticks <= 5'h00;
        end else if (bus_tick && ph_ticks != 5'h1f) begin
            ph_ticks <= ph_ticks + 5'h01;
        end
    end

    logic strobe_low;
    assign strobe_low = ~(pins_ff.rd_n & pins_ff.wr_n & pins_ff.srd_n &
                          pins_ff.swr_n & pins_ff.ds_n);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_ale_width: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_addr |->
        $past(ph_ticks) == {3'h0, tim_ff.address_phase_count}) else $error("latch width wrong");
    a_ale_addr_hold: assert property ($fell(address_latch_strobe) |->
        st_ff == ebx_pkg::st_ahold && $stable(bus_addr)) else $error("address hold wrong");
    a_cs_after_ale: assert property ($fell(chip_select_n) && is_mux |->
        $past(st_ff) == ebx_pkg::st_ahold && $past(bus_tick)) else $error("select timing wrong");
    a_setup_len: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_setup |->
        $past(ph_ticks) == {3'h0, tim_ff.data_setup_phase_count}) else $error("setup wrong");
    a_strobe_len: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_strobe |->
        $past(ph_ticks) == {1'b0, tim_ff.data_strobe_phase_count}) else $error("strobe wrong");
    a_hold_len: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_hold |->
        $past(ph_ticks) == {3'h0, tim_ff.hold_phase_count}) else $error("hold wrong");
    a_hold_pins: assert property (st_ff == ebx_pkg::st_hold |->
        !chip_select_n && !strobe_low && bus_data_oe == req_ff.write) else $error("hold pins");
    a_recov_len: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_recov |->
        $past(ph_ticks) == {1'b0, tim_ff.recovery_phase_count} && done) else $error("recovery");
    a_data_in_strobe: assert property (strobe_low && req_ff.write |->
        bus_data_oe && bus_data_out == req_ff.wdata) else $error("data missing in strobe");
    a_simplex_ale: assert property (!is_mux |-> !address_latch_strobe) else
        $error("latch strobe in simplex");
    a_strobe_map: assert property (strobe_low |-> st_ff == ebx_pkg::st_strobe &&
        ($countones({~pins_ff.rd_n, ~pins_ff.wr_n, ~pins_ff.srd_n, ~pins_ff.swr_n,
        ~pins_ff.ds_n}) == 1)) else $error("strobe mapping wrong");
    a_read_capture: assert property ($changed(st_ff) && $past(st_ff) ==
        ebx_pkg::st_strobe && !req_ff.write |-> rd_data == $past(din_s)) else
        $error("read capture wrong");
    a_launch_edge: assert property ($changed(chip_select_n) ||
        $changed(address_latch_strobe) |-> $past(bus_tick)) else $error("output off bus edge");
    a_sample_edge: assert property ($changed(burst_seen) |-> $past(bus_tick)) else
        $error("input sampled off edge");
    a_phase_order: assert property ($changed(st_ff) && $past(st_ff) == ebx_pkg::st_setup |->
        st_ff == ebx_pkg::st_strobe) else $error("phase order wrong");

    c_mux_write: cover property ($fell(address_latch_strobe) ##[1:300] $fell(write_strobe_n));
    c_simplex_read: cover property ($rose(simplex_read_strobe_n) ##[1:300] done);
    c_ds_write: cover property ($fell(single_data_strobe_n) && bus_data_oe);
    c_back_to_back: cover property (done ##[1:40] $fell(chip_select_n));

endmodule

`default_nettype wire

// ### dv/ebx_periph_model.sv
// Far-side peripheral: free-running bus clock and read data responder
`timescale 1ns/1ns
`default_nettype none
`include "ebx_cfg.svh"

module ebx_periph_model #(
    parameter int HALF_NS = 32
) (
    // Bus clock
    output logic expansion_bus_clock,
    // From the master
    input wire logic [`EBX_ADDR_W-1:0] bus_addr,
    input wire logic read_strobe_n,
    input wire logic simplex_read_strobe_n,
    input wire logic single_data_strobe_n,
    input wire logic read_not_write,
    // Towards the master
    output logic [`EBX_DATA_W-1:0] bus_data_in
);
    logic rd_act;

    assign rd_act = !read_strobe_n || !simplex_read_strobe_n
        || (!single_data_strobe_n && read_not_write);

    initial begin
        expansion_bus_clock = 1'b0;
        bus_data_in = 16'hffff;
        #3;
        forever #HALF_NS expansion_bus_clock = ~expansion_bus_clock;
    end

    // Data stands through the strobe, 2 ns past its end, then turns over
    always @(rd_act) begin
        if (rd_act) begin
            bus_data_in = bus_addr[`EBX_DATA_W-1:0] ^ 16'h5a3c;
        end else begin
            #2;
            bus_data_in = ~bus_data_in;
        end
    end
endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the expansion bus master
`timescale 1ns/1ns
`default_nettype none
`include "ebx_cfg.svh"

module testbench;
    typedef struct {
        ebx_pkg::ebx_mode_t mode;
        logic wr;
        ebx_pkg::ebx_timing_t tm;
        logic [`EBX_ADDR_W-1:0] addr;
        logic [`EBX_DATA_W-1:0] wdata;
    } ebx_row_t;

    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    ebx_pkg::ebx_mode_t bus_mode = ebx_pkg::mode_mux_rw;
    ebx_pkg::ebx_timing_t timing = '0;
    logic req_valid = 1'b0;
    ebx_pkg::ebx_req_t req = '0;
    logic target_select_in_n = 1'b1;
    logic burst_indication = 1'b0;
    logic req_ready, done, target_selected, burst_seen, expansion_bus_clock;
    logic [`EBX_DATA_W-1:0] rd_data, bus_data_in, bus_data_out, d_f, d_r;
    logic [`EBX_ADDR_W-1:0] bus_addr, p_addr;
    logic address_latch_strobe, chip_select_n, bus_data_oe, read_not_write, wait_out_n;
    logic read_strobe_n, write_strobe_n, simplex_read_strobe_n, simplex_write_strobe_n;
    logic single_data_strobe_n, oe_f, rnw_f;
    logic ale_seen = 1'b0;
    logic p_ale = 1'b0;
    logic p_cs = 1'b1;
    logic [4:0] stb, mask;
    logic [4:0] p_stb = 5'h1f;
    int cyc, t_addr, t_ale_r, t_ale_f, t_cs_f, t_cs_r, t_st_f, t_st_r, t_done;
    int err_count = 0;
    int samples_checked = 0;
    ebx_row_t rows [8];

    always #4 ref_clk = ~ref_clk;

    ebx_async_master ebx_async_master_inst (
        .ref_clk, .reset_n, .bus_mode, .timing, .req_valid, .req, .req_ready, .done,
        .rd_data, .target_selected, .burst_seen, .expansion_bus_clock, .bus_data_in,
        .target_select_in_n, .burst_indication, .address_latch_strobe, .bus_addr,
        .chip_select_n, .bus_data_out, .bus_data_oe, .read_strobe_n, .write_strobe_n,
        .simplex_read_strobe_n, .simplex_write_strobe_n, .single_data_strobe_n,
        .read_not_write, .wait_out_n
    );

    ebx_periph_model ebx_periph_model_inst (
        .expansion_bus_clock, .bus_addr, .read_strobe_n, .simplex_read_strobe_n,
        .single_data_strobe_n, .read_not_write, .bus_data_in
    );

    // Timestamps of pin edges, in ref clock cycles
    always @(negedge ref_clk) begin
        stb = {read_strobe_n, write_strobe_n, simplex_read_strobe_n,
            simplex_write_strobe_n, single_data_strobe_n};
        if (bus_addr !== p_addr) t_addr = cyc;
        if (address_latch_strobe && !p_ale) begin
            t_ale_r = cyc;
            ale_seen = 1'b1;
        end
        if (!address_latch_strobe && p_ale) t_ale_f = cyc;
        if (!chip_select_n && p_cs) t_cs_f = cyc;
        if (chip_select_n && !p_cs) t_cs_r = cyc;
        if (&p_stb && !(&stb)) begin
            t_st_f = cyc;
            mask = ~stb;
            d_f = bus_data_out;
            oe_f = bus_data_oe;
            rnw_f = read_not_write;
        end
        if (!(&p_stb) && &stb) begin
            t_st_r = cyc;
            d_r = bus_data_oe ? bus_data_out : ~bus_data_out;
        end
        if (done === 1'b1) t_done = cyc;
        p_addr = bus_addr;
        p_ale = address_latch_strobe;
        p_cs = chip_select_n;
        p_stb = stb;
        cyc++;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [4:0] exp_mask(input ebx_pkg::ebx_mode_t m, input logic w);
        case (m)
            ebx_pkg::mode_mux_rw: exp_mask = w ? 5'h08 : 5'h10;
            ebx_pkg::mode_simplex_rw: exp_mask = w ? 5'h02 : 5'h04;
            default: exp_mask = 5'h01;
        endcase
    endfunction

    task automatic check_idle();
        check("idle pins", {address_latch_strobe, chip_select_n, bus_data_oe, read_strobe_n,
            write_strobe_n, simplex_read_strobe_n, simplex_write_strobe_n, single_data_strobe_n,
            req_ready, done, read_not_write, wait_out_n}, 12'h5fb);
    endtask

    task automatic launch(input ebx_row_t r);
        ale_seen = 1'b0;
        @(posedge ref_clk);
        bus_mode <= r.mode;
        timing <= r.tm;
        req <= '{r.wr, r.addr, r.wdata};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
    endtask

    task automatic run_row(input ebx_row_t r);
        int n;
        n = 0;
        launch(r);
        do begin
            @(negedge ref_clk);
            n++;
        end while (done !== 1'b1 && n < 2000);
        // Let the edge timestamps of this negedge settle
        #1;
        check("done", done, 1'b1);
        if (r.mode[0]) begin
            check("select after address", t_cs_f - t_addr,
                (r.tm.address_phase_count + 1) * 8);
            check("latch unused", ale_seen, 1'b0);
        end else begin
            check("latch width", t_ale_f - t_ale_r, (r.tm.address_phase_count + 1) * 8);
            check("address at latch", t_addr, t_ale_r);
            check("select after latch", t_cs_f - t_ale_f, 8);
        end
        check("address held", bus_addr, r.addr);
        check("setup", t_st_f - t_cs_f, (r.tm.data_setup_phase_count + 1) * 8);
        check("strobe width", t_st_r - t_st_f, (r.tm.data_strobe_phase_count + 1) * 8);
        check("hold", t_cs_r - t_st_r, (r.tm.hold_phase_count + 1) * 8);
        check("recovery", t_done - t_cs_r, (r.tm.recovery_phase_count + 1) * 8);
        check("strobe used", mask, exp_mask(r.mode, r.wr));
        check("drive enable", oe_f, r.wr);
        if (r.wr) begin
            check("data at strobe", d_f, r.wdata);
            check("data after strobe", d_r, r.wdata);
        end else begin
            check("read data", rd_data, r.addr[`EBX_DATA_W-1:0] ^ 16'h5a3c);
        end
        if (r.mode[1]) check("direction", rnw_f, !r.wr);
    endtask

    initial begin
        #400000;
        err_count++;
        finish_test();
    end

    initial begin
        int n;
        rows = '{
            '{ebx_pkg::mode_mux_rw, 1'b1, {2'h0, 2'h0, 4'h0, 2'h0, 4'h0}, 24'h000101, 16'h1234},
            '{ebx_pkg::mode_mux_rw, 1'b0, {2'h3, 2'h3, 4'hf, 2'h3, 4'hf}, 24'h00a202, 16'h0000},
            '{ebx_pkg::mode_simplex_rw, 1'b1, {2'h1, 2'h2, 4'h5, 2'h3, 4'h2},
                24'h123303, 16'hbeef},
            '{ebx_pkg::mode_simplex_rw, 1'b0, {2'h0, 2'h0, 4'h0, 2'h0, 4'h0},
                24'hfff404, 16'h0000},
            '{ebx_pkg::mode_mux_ds, 1'b1, {2'h3, 2'h1, 4'hf, 2'h0, 4'h7}, 24'h0c5505, 16'h8001},
            '{ebx_pkg::mode_mux_ds, 1'b0, {2'h2, 2'h0, 4'h3, 2'h1, 4'h0}, 24'h306606, 16'h0000},
            '{ebx_pkg::mode_simplex_ds, 1'b1, {2'h3, 2'h3, 4'hf, 2'h3, 4'hf},
                24'h777707, 16'h5aa5},
            '{ebx_pkg::mode_simplex_ds, 1'b0, {2'h1, 2'h3, 4'h0, 2'h2, 4'h1},
                24'h808808, 16'h0000}
        };
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        check_idle();
        @(posedge ref_clk);
        target_select_in_n <= 1'b0;
        burst_indication <= 1'b1;
        repeat (24) @(posedge ref_clk);
        check("target selected", {target_selected, burst_seen}, 2'b11);
        target_select_in_n <= 1'b1;
        burst_indication <= 1'b0;
        repeat (24) @(posedge ref_clk);
        check("target released", {target_selected, burst_seen}, 2'b00);
        for (int i = 0; i < 8; i++) begin
            run_row(rows[i]);
        end
        // Request while busy is ignored
        fork
            run_row(rows[1]);
            begin
                repeat (40) @(posedge ref_clk);
                req <= '{1'b1, 24'h0bad00, 16'hffff};
                req_valid <= 1'b1;
                @(posedge ref_clk);
                req_valid <= 1'b0;
            end
        join
        repeat (40) @(posedge ref_clk);
        check("no stray access", {req_ready, bus_addr}, {1'b1, rows[1].addr});
        // Reset in mid-access
        launch(rows[2]);
        n = 0;
        while (chip_select_n !== 1'b0 && n < 1000) begin
            @(posedge ref_clk);
            n++;
        end
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check_idle();
        @(posedge ref_clk);
        reset_n <= 1'b1;
        run_row(rows[0]);
        finish_test();
    end
endmodule

`default_nettype wire
